//--- adcc_core.sv
// register file and successive-approximation sequencer of the converter
`timescale 1ns/10ps
`include "adcc_cfg.svh"
// Function
// - channel field bits 5-2 routes input 0-13, 14 reserved, 15 fixed reference
// - writing one to go bit starts conversion only if the same write also sets the enable bit; go reads one while busy
// - hardware clears go bit when conversion finishes
// - enable bit powers converter; clear means disabled, no operating current
// - clock select bits 6-4 pick divide 2..64 or the RC clock
// - reference bits 1-0: 0x supply, 10 external pin, 11 fixed reference
// - result register holds the 8-bit outcome, readable by software
// - unimplemented control bits read as zero
// - one conversion takes exactly ten per-bit periods
// - completion clears go, sets done flag, loads result
// - abort by clearing go stores partial result, tail copies last bit
module adcc_core
    import adcc_pkg::*;
(
    input  wire logic                    clk_i,
    input  wire logic                    arst_n_i,
    input  wire logic [`ADCC_ADDR_W-1:0] addr_i,
    input  wire logic [7:0]              wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    output logic      [7:0]              rdata_o,
    input  wire logic                    cmp_i,
    input  wire logic                    rc_tick_i,
    output logic      [3:0]              input_channel_select_o,
    output logic      [1:0]              reference_source_select_o,
    output logic                         converter_power_on_o,
    output logic                         hold_o,
    output logic      [7:0]              dac_code_o,
    output logic                         conv_irq_o
);
    adcc_tick_if tk ();

    adcc_tad_gen u_tad (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .tk       (tk.gen)
    );

    adcc_state_t state_r;
    logic [3:0]  chan_r;
    logic        power_on_r;
    adcc_cks_t   cks_r;
    logic [1:0]  ref_r;
    logic [7:0]  result_r;
    logic        done_flag_r;
    logic        irq_en_r;
    logic [3:0]  tad_cnt_r;
    logic [7:0]  sar_r;

    logic        wr_c0;
    logic        wr_c1;
    logic        wr_res;
    logic        wr_st;
    logic        start;
    logic        abort;
    logic        resolve;
    logic        finish;
    logic [2:0]  bit_idx;
    logic [7:0]  sar_nxt;
    logic [7:0]  partial;

    assign wr_c0  = wr_i && addr_i == `ADCC_OFS_CTRL0;
    assign wr_c1  = wr_i && addr_i == `ADCC_OFS_CTRL1;
    assign wr_res = wr_i && addr_i == `ADCC_OFS_RESULT;
    assign wr_st  = wr_i && addr_i == `ADCC_OFS_STATUS;

    // a start needs the enable bit set by the same write as the go bit
    assign start = wr_c0 && state_r == ADCC_IDLE
                   && wdata_i[`ADCC_C0_GO_BIT]
                   && wdata_i[`ADCC_C0_ON_BIT];
    // turning power off also ends a running conversion
    assign abort = wr_c0 && state_r == ADCC_CONV
                   && (!wdata_i[`ADCC_C0_GO_BIT]
                       || !wdata_i[`ADCC_C0_ON_BIT]);
    assign resolve = state_r == ADCC_CONV && tk.tick
                     && tad_cnt_r >= `ADCC_TAD_FIRST_BIT
                     && tad_cnt_r <= `ADCC_TAD_LAST_BIT;
    assign finish  = state_r == ADCC_CONV && tk.tick && !abort
                     && tad_cnt_r == `ADCC_TAD_PER_CONV - 4'h1;
    assign bit_idx = 3'(`ADCC_TAD_LAST_BIT - tad_cnt_r);

    assign tk.clk_sel = cks_r;
    assign tk.run     = state_r == ADCC_CONV;
    assign tk.rc_tick = rc_tick_i;

    // keep the compared bit, try the next lower one
    always_comb begin
        sar_nxt          = sar_r;
        sar_nxt[bit_idx] = cmp_i;
        if (bit_idx != 3'h0) begin
            sar_nxt[bit_idx - 3'h1] = 1'b1;
        end
    end

    // bits not yet resolved copy the last resolved bit
    always_comb begin
        logic [3:0] left;
        logic       last;
        left    = `ADCC_TAD_LAST_BIT;
        last    = 1'b0;
        partial = 8'h00;
        if (tad_cnt_r > `ADCC_TAD_FIRST_BIT) begin
            left = (tad_cnt_r > `ADCC_TAD_LAST_BIT) ? 4'h0
                   : 4'(`ADCC_TAD_LAST_BIT - tad_cnt_r + 4'h1);
            last = sar_r[3'(left)];
            for (int i = 0; i < 8; i++) begin
                partial[i] = (4'(i) < left) ? last : sar_r[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chan_r     <= 4'(`ADCC_CTRL0_RST >> `ADCC_C0_CHS_LSB);
            power_on_r <= 1'(`ADCC_CTRL0_RST >> `ADCC_C0_ON_BIT);
        end else if (wr_c0) begin
            chan_r     <= wdata_i[`ADCC_C0_CHS_MSB:`ADCC_C0_CHS_LSB];
            power_on_r <= wdata_i[`ADCC_C0_ON_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cks_r <= 3'(`ADCC_CTRL1_RST >> `ADCC_C1_CKS_LSB);
            ref_r <= 2'(`ADCC_CTRL1_RST >> `ADCC_C1_REF_LSB);
        end else if (wr_c1) begin
            cks_r <= wdata_i[`ADCC_C1_CKS_MSB:`ADCC_C1_CKS_LSB];
            ref_r <= wdata_i[`ADCC_C1_REF_MSB:`ADCC_C1_REF_LSB];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= ADCC_IDLE;
        end else if (start) begin
            state_r <= ADCC_CONV;
        end else if (abort || finish) begin
            state_r <= ADCC_IDLE;
        end
    end

    // period counter on the per-bit clock
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tad_cnt_r <= 4'h0;
            sar_r     <= 8'h00;
        end else if (start) begin
            tad_cnt_r <= 4'h0;
            sar_r     <= `ADCC_SAR_SEED;
        end else if (state_r == ADCC_CONV && tk.tick) begin
            tad_cnt_r <= tad_cnt_r + 4'h1;
            if (resolve) begin
                sar_r <= sar_nxt;
            end
        end
    end

    // result register, hardware load beats software write
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            result_r <= `ADCC_RESULT_RST;
        end else if (finish) begin
            result_r <= sar_r;
        end else if (abort) begin
            result_r <= partial;
        end else if (wr_res) begin
            result_r <= wdata_i;
        end
    end

    // done flag: completion wins over a clear in the same cycle
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            done_flag_r <= 1'(`ADCC_STATUS_RST >> `ADCC_ST_DONE_BIT);
            irq_en_r    <= 1'(`ADCC_STATUS_RST >> `ADCC_ST_IRQEN_BIT);
        end else begin
            if (finish) begin
                done_flag_r <= 1'b1;
            end else if (wr_st && wdata_i[`ADCC_ST_DONE_BIT]) begin
                done_flag_r <= 1'b0;
            end
            if (wr_st) begin
                irq_en_r <= wdata_i[`ADCC_ST_IRQEN_BIT];
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            unique case (addr_i)
                `ADCC_OFS_CTRL0:  rdata_o <= {2'h0, chan_r,
                                              state_r == ADCC_CONV,
                                              power_on_r};
                `ADCC_OFS_CTRL1:  rdata_o <= {1'b0, cks_r, 2'h0, ref_r};
                `ADCC_OFS_RESULT: rdata_o <= result_r;
                `ADCC_OFS_STATUS: rdata_o <= {6'h00, irq_en_r,
                                              done_flag_r};
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // analog side controls and interrupt, all registered
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            input_channel_select_o    <= 4'h0;
            reference_source_select_o <= 2'h0;
            converter_power_on_o      <= 1'b0;
            hold_o                    <= 1'b0;
            dac_code_o                <= 8'h00;
            conv_irq_o                <= 1'b0;
        end else begin
            input_channel_select_o    <= chan_r;
            reference_source_select_o <= ref_r;
            converter_power_on_o      <= power_on_r;
            hold_o                    <= state_r == ADCC_CONV;
            dac_code_o                <= sar_r;
            conv_irq_o                <= done_flag_r & irq_en_r;
        end
    end
endmodule : adcc_core

//--- adcc_cfg.svh
// offsets, field positions, reset values and counts of the converter control
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

`define ADCC_ADDR_W        2
`define ADCC_OFS_CTRL0     2'h0
`define ADCC_OFS_CTRL1     2'h1
`define ADCC_OFS_RESULT    2'h2
`define ADCC_OFS_STATUS    2'h3

`define ADCC_CTRL0_RST     8'h00
`define ADCC_CTRL1_RST     8'h00
`define ADCC_RESULT_RST    8'h00
`define ADCC_STATUS_RST    8'h00

`define ADCC_C0_ON_BIT     0
`define ADCC_C0_GO_BIT     1
`define ADCC_C0_CHS_LSB    2
`define ADCC_C0_CHS_MSB    5
`define ADCC_C1_REF_LSB    0
`define ADCC_C1_REF_MSB    1
`define ADCC_C1_CKS_LSB    4
`define ADCC_C1_CKS_MSB    6
`define ADCC_ST_DONE_BIT   0
`define ADCC_ST_IRQEN_BIT  1

`define ADCC_CHS_RESERVED  4'he
`define ADCC_CKS_RC_MASK   3'h3
`define ADCC_TAD_PER_CONV  4'ha
`define ADCC_TAD_FIRST_BIT 4'h1
`define ADCC_TAD_LAST_BIT  4'h8
`define ADCC_SAR_SEED      8'h80

`endif

//--- adcc_pkg.sv
// types shared by the converter control modules
package adcc_pkg;
    typedef enum logic [0:0] {
        ADCC_IDLE = 1'b0,
        ADCC_CONV = 1'b1
    } adcc_state_t;

    typedef logic [2:0] adcc_cks_t;
endpackage : adcc_pkg

//--- adcc_tick_if.sv
// per-bit clock request and tick between control and divider
`timescale 1ns/10ps
interface adcc_tick_if;
    logic [2:0] clk_sel;
    logic       run;
    logic       rc_tick;
    logic       tick;

    modport gen  (input clk_sel, input run, input rc_tick, output tick);
    modport user (output clk_sel, output run, output rc_tick, input tick);
endinterface : adcc_tick_if

//--- adcc_tad_gen.sv
// per-bit period divider: one-cycle tick per conversion clock period
`timescale 1ns/10ps
`include "adcc_cfg.svh"
module adcc_tad_gen
    import adcc_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   arst_n_i,
    adcc_tick_if.gen    tk
);
    logic [6:0] div_cnt_r;
    logic [6:0] div_last;
    logic       rc_sel;
    logic [2:0] div_exp;

    // code order 000,100,001,101,010,110 maps onto /2 .. /64
    assign div_exp  = {tk.clk_sel[1:0], tk.clk_sel[2]};
    assign div_last = 7'((7'h2 << div_exp) - 7'h1);
    assign rc_sel   = (tk.clk_sel[1:0] == 2'(`ADCC_CKS_RC_MASK));

    // restarting the count on each run keeps every divided period whole
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_cnt_r <= 7'h00;
        end else if (!tk.run || rc_sel || div_cnt_r == div_last) begin
            div_cnt_r <= 7'h00;
        end else begin
            div_cnt_r <= div_cnt_r + 7'h1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tk.tick <= 1'b0;
        end else if (rc_sel) begin
            tk.tick <= tk.run & tk.rc_tick;
        end else begin
            tk.tick <= tk.run & (div_cnt_r == div_last);
        end
    end
endmodule : adcc_tad_gen

//--- adcc_core_asserts.sv
// port-level checker for the converter control core
`timescale 1ns/10ps
`include "adcc_cfg.svh"
module adcc_core_asserts (
    input wire logic       clk_i,
    input wire logic       arst_n_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [3:0] input_channel_select_o,
    input wire logic [1:0] reference_source_select_o,
    input wire logic       converter_power_on_o,
    input wire logic       hold_o,
    input wire logic [7:0] dac_code_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_wr_res;
        wr_i && addr_i == `ADCC_OFS_RESULT && !hold_o;
    endsequence
    sequence s_rd_res;
        rd_i && addr_i == `ADCC_OFS_RESULT;
    endsequence
    property p_res_rw;
        s_wr_res ##1 s_rd_res |=> rdata_o == $past(wdata_i, 2);
    endproperty
    a_res_rw: assert property (p_res_rw) else $error("result readback");
    property p_c0_zero;
        rd_i && addr_i == `ADCC_OFS_CTRL0 |=> rdata_o[7:6] == 2'h0;
    endproperty
    a_c0_zero: assert property (p_c0_zero) else $error("ctrl0 spare");
    property p_c1_zero;
        rd_i && addr_i == `ADCC_OFS_CTRL1 |=>
            rdata_o[7] == 1'b0 && rdata_o[3:2] == 2'h0;
    endproperty
    a_c1_zero: assert property (p_c1_zero) else $error("ctrl1 spare");
    property p_on;
        wr_i && addr_i == `ADCC_OFS_CTRL0 |=> ##1
            converter_power_on_o == $past(wdata_i[0], 2);
    endproperty
    a_on: assert property (p_on) else $error("enable output");
    property p_chan;
        wr_i && addr_i == `ADCC_OFS_CTRL0 |=> ##1
            input_channel_select_o == $past(wdata_i[5:2], 2);
    endproperty
    a_chan: assert property (p_chan) else $error("channel output");
    property p_ref;
        wr_i && addr_i == `ADCC_OFS_CTRL1 |=> ##1
            reference_source_select_o == $past(wdata_i[1:0], 2);
    endproperty
    a_ref: assert property (p_ref) else $error("reference output");
    property p_end;
        $rose(hold_o) |-> ##[1:700] !hold_o;
    endproperty
    a_end: assert property (p_end) else $error("conversion hangs");
    property p_seed;
        $rose(hold_o) |-> ##[0:1] dac_code_o == `ADCC_SAR_SEED;
    endproperty
    a_seed: assert property (p_seed) else $error("msb trial");
    property p_start_on;
        $rose(hold_o) |-> converter_power_on_o;
    endproperty
    a_start_on: assert property (p_start_on) else $error("start off");
endmodule : adcc_core_asserts
bind adcc_core adcc_core_asserts u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .input_channel_select_o(input_channel_select_o),
    .reference_source_select_o(reference_source_select_o),
    .converter_power_on_o(converter_power_on_o), .hold_o(hold_o),
    .dac_code_o(dac_code_o));

//--- tb_adcc_core.sv
// self-checking bench for the converter control core
`timescale 1ns/10ps
`include "adcc_cfg.svh"
module tb_adcc_core;
    logic       clk_i = 1'b0, arst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [1:0] addr_i = 2'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o, dac_code_o, tgt = 8'h00;
    logic       cmp_i, rc_tick_i = 1'b0, on_o, hold_o, irq_o;
    logic [3:0] chan_o;
    logic [1:0] ref_o;
    int         failures = 0, comparisons = 0, rc_cnt = 0;
    int         hold_len = 0, last_len = 0;
    // ideal comparator so a full conversion must return tgt
    assign cmp_i = (tgt >= dac_code_o);
    adcc_core dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .cmp_i(cmp_i), .rc_tick_i(rc_tick_i),
        .input_channel_select_o(chan_o), .reference_source_select_o(ref_o),
        .converter_power_on_o(on_o), .hold_o(hold_o),
        .dac_code_o(dac_code_o), .conv_irq_o(irq_o));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    // rc clock: one pulse every five cycles
    always @(posedge clk_i) begin
        rc_cnt <= (rc_cnt == 4) ? 0 : rc_cnt + 1;
        rc_tick_i <= (rc_cnt == 4);
        hold_len <= hold_o ? hold_len + 1 : 0;
        if (!hold_o && hold_len != 0) last_len <= hold_len;
    end
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task chk_rng(input string n, input int lo, input int hi, input int g);
        comparisons++;
        if (g < lo || g > hi) begin
            failures++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask : chk_rng
    task wr(input logic [1:0] a, input logic [7:0] d);
        // a write just issued still shows its strobe: let one edge pass
        if (wr_i) begin
            @(posedge clk_i);
        end
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task rd(input logic [1:0] a, output logic [7:0] d);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        d = rdata_o;
        @(posedge clk_i);
    endtask : rd
    task rchk(input string n, input logic [1:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(n, e, d);
    endtask : rchk
    task wait_idle;
        logic [7:0] d;
        int n;
        n = 0;
        rd(`ADCC_OFS_CTRL0, d);
        chk("go busy", 8'h02, d & 8'h02);
        while (d[1] !== 1'b0) begin
            n++;
            if (n > 500) begin
                failures++;
                end_of_test;
            end
            rd(`ADCC_OFS_CTRL0, d);
        end
    endtask : wait_idle
    task t_regs;
        rchk("ctrl0 rst", `ADCC_OFS_CTRL0, 8'h00);
        rchk("ctrl1 rst", `ADCC_OFS_CTRL1, 8'h00);
        rchk("status rst", `ADCC_OFS_STATUS, 8'h00);
        wr(`ADCC_OFS_CTRL0, 8'hfd);
        rchk("ctrl0 spare", `ADCC_OFS_CTRL0, 8'h3d);
        wr(`ADCC_OFS_CTRL1, 8'hff);
        rchk("ctrl1 spare", `ADCC_OFS_CTRL1, 8'h73);
        // start with the converter off must be ignored
        wr(`ADCC_OFS_CTRL0, 8'h3a);
        rchk("start off", `ADCC_OFS_CTRL0, 8'h38);
        wr(`ADCC_OFS_RESULT, 8'h5a);
        rchk("result rw", `ADCC_OFS_RESULT, 8'h5a);
        for (int i = 0; i < 16; i++) begin
            wr(`ADCC_OFS_CTRL0, {2'h0, i[3:0], 1'b0, i[0]});
            wr(`ADCC_OFS_CTRL1, {6'h00, i[1:0]});
            @(posedge clk_i);
            #1 chk("chan", {4'h0, i[3:0]}, {4'h0, chan_o});
            chk("ref", {6'h00, i[1:0]}, {6'h00, ref_o});
            chk("on", {7'h00, i[0]}, {7'h00, on_o});
            @(posedge clk_i);
        end
    endtask : t_regs
    task t_conv;
        int cks[8];
        int dv[8];
        cks = '{0, 4, 1, 5, 2, 6, 3, 7};
        dv = '{2, 4, 8, 16, 32, 64, 5, 5};
        wr(`ADCC_OFS_STATUS, 8'h02);
        for (int i = 0; i < 8; i++) begin
            tgt <= 8'h5a + 8'(i * 27);
            wr(`ADCC_OFS_CTRL1, 8'(cks[i] << 4));
            wr(`ADCC_OFS_CTRL0, 8'h01);
            repeat (5) @(posedge clk_i);
            wr(`ADCC_OFS_CTRL0, 8'h03);
            // poll go until it reads zero
            wait_idle;
            // the length tracker settles one edge after hold falls
            @(posedge clk_i);
            chk_rng("length", 9 * dv[i], 10 * dv[i] + 3, last_len);
            rchk("result", `ADCC_OFS_RESULT, tgt);
            rchk("done", `ADCC_OFS_STATUS, 8'h03);
            chk("irq", 8'h01, {7'h00, irq_o});
            wr(`ADCC_OFS_STATUS, 8'h03);
            rchk("done clr", `ADCC_OFS_STATUS, 8'h02);
            chk("irq clr", 8'h00, {7'h00, irq_o});
        end
    endtask : t_conv
    task t_abort;
        tgt <= 8'h80;
        wr(`ADCC_OFS_CTRL1, 8'h60);
        wr(`ADCC_OFS_CTRL0, 8'h01);
        repeat (5) @(posedge clk_i);
        wr(`ADCC_OFS_CTRL0, 8'h03);
        // only the msb is resolved by now at divide-by-64
        repeat (160) @(posedge clk_i);
        wr(`ADCC_OFS_CTRL0, 8'h01);
        rchk("abort go", `ADCC_OFS_CTRL0, 8'h01);
        rchk("partial", `ADCC_OFS_RESULT, 8'hff);
        rchk("no done", `ADCC_OFS_STATUS, 8'h02);
    endtask : t_abort
    task end_of_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        t_regs;
        t_conv;
        t_abort;
        end_of_test;
    end
endmodule : tb_adcc_core
